// File: src/slbc_defs.vh
// Constants for the serial link self-test control block.
// Assumes inclusion by bare name from the port checker and top design files of the block.
// Summary of operation
// - Writing 0x01 to test control starts the test; writing zero stops it.
// - Test start issues back-channel writes placing the remote serializer in test mode.
// - Each receive port checks the incoming sequence and counts its errors.
// - Error tally saturates at 0xFE; reads 0xFF when lock never came or was lost.
// - Per-port pass indication pulses low for each detected data error during test.
// - Gating field bits 7:6: code 00 disables outputs, code 10 keeps them enabled.
// - With outputs enabled, CSI-2 stays LP-11 unless pattern generator is enabled.
// - Clock select field is written into remote register 0x14 bits 2:1.
// - Clock select is sampled only at test start; later changes are ignored.
// - Read-only remote test-active status at per-port debug register 0xD0 bit 5.
// - Registers reachable from both local I2C target and control channel.
// - Per-port registers 0x46-0x7F paged: 0x4C[5:4] reads, 0x4C[3:0] write enables.
// - Per-port debug registers 0xD0-0xDF use the same paging.
// - CSI-2 registers 0x33-0x3A paged: read when 0x32[4]=0, write when 0x32[0]=1.
`ifndef SLBC_DEFS_VH
`define SLBC_DEFS_VH

`define SLBC_A_CSI_SEL     8'h32
`define SLBC_A_CSI_LO      8'h33
`define SLBC_A_CSI_HI      8'h3a
`define SLBC_A_RX_LO       8'h46
`define SLBC_A_RX_SEL      8'h4c
`define SLBC_A_TALLY       8'h57
`define SLBC_A_RX_HI       8'h7f
`define SLBC_A_CTRL        8'hb3
`define SLBC_A_DBG         8'hd0
`define SLBC_A_DBG_HI      8'hdf

`define SLBC_RST_BYTE      8'h00
`define SLBC_ZERO_BYTE     8'h00

`define SLBC_CTRL_EN       0
`define SLBC_CTRL_CLK_HI   2
`define SLBC_CTRL_CLK_LO   1
`define SLBC_CTRL_GATE_HI  7
`define SLBC_CTRL_GATE_LO  6
`define SLBC_GATE_ON       2'b10

`define SLBC_CSI_RSEL      4
`define SLBC_CSI_WEN       0
`define SLBC_RX_RSEL_HI    5
`define SLBC_RX_RSEL_LO    4
`define SLBC_DBG_ACT       5
`define SLBC_DBG_RW_MASK   8'hdf

`define SLBC_SER_REG       8'h14
`define SLBC_SER_PAD       5'h00
`define SLBC_PORT_ALL      4'hf

`define SLBC_TALLY_MAX     8'hfe
`define SLBC_TALLY_NOLOCK  8'hff
`define SLBC_TALLY_ONE     8'h01

`define SLBC_PRBS_W        7
`define SLBC_PRBS_TAP_A    6
`define SLBC_PRBS_TAP_B    5
`define SLBC_FILL_FULL     3'h7
`define SLBC_FILL_ONE      3'h1
`define SLBC_FILL_ZERO     3'h0

`endif

// File: src/slbc_sync2.v
// Two-flop synchroniser for levels arriving from outside the core clock.
// Assumes the inputs are slow levels; a pulse survives only if a rising edge samples it.
`timescale 1ns/1ps
module slbc_sync2 #(
    parameter W = 4
) (
    input  wire         clock_in,
    input  wire         nrst_in,
    input  wire         ce_in,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta;

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            meta     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else if (ce_in) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// File: src/slbc_port_checker.v
// Per receive port pattern checker with saturating error tally and pass flag.
// Assumes a deserialized bit stream on the core clock and an already synced lock.
`timescale 1ns/1ps
`include "slbc_defs.vh"
module slbc_port_checker (
    input  wire       clock_in,
    input  wire       nrst_in,
    input  wire       ce_in,
    input  wire       clear_in,
    input  wire       run_in,
    input  wire       lock_in,
    input  wire       bit_in,
    input  wire       bit_valid_in,
    output wire [7:0] tally_out,
    output reg        pass_out
);
    reg [`SLBC_PRBS_W-1:0] hist;
    reg [2:0]              fill;
    reg [7:0]              count;
    reg                    started;
    reg                    seen_lock;
    reg                    lost_lock;
    wire                   predicted;
    wire                   take;
    wire                   data_err;

    // Self-synchronising check: the sequence is predicted from the last seven bits
    assign predicted = hist[`SLBC_PRBS_TAP_A] ^ hist[`SLBC_PRBS_TAP_B];
    assign take      = run_in & lock_in & bit_valid_in;
    assign data_err  = take & (fill == `SLBC_FILL_FULL) & (bit_in != predicted);

    assign tally_out = (started & (~seen_lock | lost_lock)) ? `SLBC_TALLY_NOLOCK : count;

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            hist      <= {`SLBC_PRBS_W{1'b0}};
            fill      <= `SLBC_FILL_ZERO;
            count     <= `SLBC_ZERO_BYTE;
            started   <= 1'b0;
            seen_lock <= 1'b0;
            lost_lock <= 1'b0;
            pass_out  <= 1'b1;
        end else if (ce_in) begin
            if (clear_in) begin
                fill      <= `SLBC_FILL_ZERO;
                count     <= `SLBC_ZERO_BYTE;
                started   <= 1'b1;
                seen_lock <= 1'b0;
                lost_lock <= 1'b0;
                pass_out  <= 1'b1;
            end else begin
                if (run_in) begin
                    if (lock_in) begin
                        seen_lock <= 1'b1;
                    end else if (seen_lock) begin
                        lost_lock <= 1'b1;
                    end
                end
                // Losing lock forces a fresh seed so stale bits raise no false errors
                if (!lock_in || !run_in) begin
                    fill <= `SLBC_FILL_ZERO;
                end else if (take) begin
                    hist <= {hist[`SLBC_PRBS_W-2:0], bit_in};
                    if (fill != `SLBC_FILL_FULL) begin
                        fill <= fill + `SLBC_FILL_ONE;
                    end
                end
                if (data_err && count < `SLBC_TALLY_MAX) begin
                    count <= count + `SLBC_TALLY_ONE;
                end
                pass_out <= ~data_err;
            end
        end
    end
endmodule

// File: src/slbc_link_test.v
// Link self-test top: register file, test sequencer, four port checkers.
// Assumes both register ports arrive as byte requests on clock_in and
// that the back-channel writer acks each request with a one-cycle pulse.
`timescale 1ns/1ps
`include "slbc_defs.vh"
module slbc_link_test (
    input  wire       clock_in,
    input  wire       nrst_in,
    input  wire       ce_in,
    // Local I2C target register port
    input  wire [7:0] loc_addr_in,
    input  wire [7:0] loc_wdata_in,
    input  wire       loc_wr_in,
    input  wire       loc_rd_in,
    output reg  [7:0] loc_rdata_out,
    output reg        loc_rvalid_out,
    // Control-channel register port
    input  wire [7:0] cc_addr_in,
    input  wire [7:0] cc_wdata_in,
    input  wire       cc_wr_in,
    input  wire       cc_rd_in,
    output wire       cc_ready_out,
    output reg  [7:0] cc_rdata_out,
    output reg        cc_rvalid_out,
    // Back-channel writes to the remote serializers
    output wire       bc_req_out,
    output wire [3:0] bc_port_mask_out,
    output wire [7:0] bc_addr_out,
    output reg  [7:0] bc_data_out,
    input  wire       bc_ack_in,
    // Receive ports
    input  wire [3:0] rx_lock_in,
    input  wire [3:0] rx_bit_in,
    input  wire [3:0] rx_bit_valid_in,
    input  wire [3:0] remote_test_active_in,
    output wire [3:0] pass_out,
    // Output control
    input  wire       pattgen_en_in,
    output wire       test_active_out,
    output wire       output_enable_out,
    output wire       csi_lp11_hold_out,
    output wire       csi_tx_enable_out
);
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_RUN   = 4'b0100;
    localparam [3:0] ST_STOP  = 4'b1000;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [7:0]  link_test_control;
    reg  [7:0]  csi_port_page_select;
    reg  [7:0]  rx_port_page_select;
    reg  [7:0]  csi_regs [0:7];
    reg  [7:0]  dbg_scratch [0:3];
    reg  [1:0]  clk_sel_held;
    reg         clear_pulse;
    reg  [7:0]  rd_mux;
    wire [3:0]  lock_sync;
    wire [31:0] tally_all;
    wire        loc_busy;
    wire        acc_wr;
    wire        acc_rd;
    wire [7:0]  acc_addr;
    wire [7:0]  acc_wdata;
    wire [1:0]  rx_rsel;
    wire [2:0]  csi_idx;
    wire [7:0]  csi_off;
    wire        in_csi;
    wire        test_en;
    wire [1:0]  test_output_gating;
    wire [1:0]  test_clock_select;
    integer     i;

    // Local port wins; control channel is held off by ready
    assign loc_busy     = loc_wr_in | loc_rd_in;
    assign cc_ready_out = ~loc_busy;
    assign acc_wr       = loc_busy ? loc_wr_in : cc_wr_in;
    assign acc_rd       = loc_busy ? loc_rd_in : cc_rd_in;
    assign acc_addr     = loc_busy ? loc_addr_in : cc_addr_in;
    assign acc_wdata    = loc_busy ? loc_wdata_in : cc_wdata_in;

    assign test_en            = link_test_control[`SLBC_CTRL_EN];
    assign test_output_gating = link_test_control[`SLBC_CTRL_GATE_HI:`SLBC_CTRL_GATE_LO];
    assign test_clock_select  = link_test_control[`SLBC_CTRL_CLK_HI:`SLBC_CTRL_CLK_LO];
    assign rx_rsel            = rx_port_page_select[`SLBC_RX_RSEL_HI:`SLBC_RX_RSEL_LO];
    assign csi_off            = acc_addr - `SLBC_A_CSI_LO;
    assign csi_idx            = csi_off[2:0];
    assign in_csi             = (acc_addr >= `SLBC_A_CSI_LO) && (acc_addr <= `SLBC_A_CSI_HI);

    // Lock comes from the analog recovery loop, so it is synchronised first
    slbc_sync2 #(
        .W (4)
    ) u_lock_sync (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .ce_in    (ce_in),
        .async_in (rx_lock_in),
        .sync_out (lock_sync)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_port
            slbc_port_checker u_chk (
                .clock_in     (clock_in),
                .nrst_in      (nrst_in),
                .ce_in        (ce_in),
                .clear_in     (clear_pulse),
                .run_in       (state == ST_RUN),
                .lock_in      (lock_sync[g]),
                .bit_in       (rx_bit_in[g]),
                .bit_valid_in (rx_bit_valid_in[g]),
                .tally_out    (tally_all[g*8+7:g*8]),
                .pass_out     (pass_out[g])
            );
        end
    endgenerate

    // Sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (test_en) begin
                    next_state = ST_START;
                end
            end
            ST_START: begin
                if (bc_ack_in) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!test_en) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (bc_ack_in) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            state        <= ST_IDLE;
            clk_sel_held <= 2'b00;
            clear_pulse  <= 1'b0;
            bc_data_out  <= `SLBC_ZERO_BYTE;
        end else if (ce_in) begin
            state       <= next_state;
            clear_pulse <= 1'b0;
            if (state == ST_IDLE && test_en) begin
                clk_sel_held <= test_clock_select;
                clear_pulse  <= 1'b1;
                bc_data_out  <= {`SLBC_SER_PAD, test_clock_select, 1'b1};
            end else if (state == ST_RUN && !test_en) begin
                bc_data_out <= {`SLBC_SER_PAD, clk_sel_held, 1'b0};
            end
        end
    end

    assign bc_req_out       = (state == ST_START) | (state == ST_STOP);
    assign bc_port_mask_out = `SLBC_PORT_ALL;
    assign bc_addr_out      = `SLBC_SER_REG;

    assign test_active_out   = (state != ST_IDLE);
    assign output_enable_out = ~test_active_out | (test_output_gating == `SLBC_GATE_ON);
    assign csi_lp11_hold_out = test_active_out & ~pattgen_en_in;
    assign csi_tx_enable_out = csi_regs[0][0];

    // Register writes
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            link_test_control    <= `SLBC_RST_BYTE;
            csi_port_page_select <= `SLBC_RST_BYTE;
            rx_port_page_select  <= `SLBC_RST_BYTE;
            for (i = 0; i < 8; i = i + 1) begin
                csi_regs[i] <= `SLBC_RST_BYTE;
            end
            for (i = 0; i < 4; i = i + 1) begin
                dbg_scratch[i] <= `SLBC_RST_BYTE;
            end
        end else if (ce_in && acc_wr) begin
            if (acc_addr == `SLBC_A_CTRL) begin
                link_test_control <= acc_wdata;
            end else if (acc_addr == `SLBC_A_CSI_SEL) begin
                csi_port_page_select <= acc_wdata;
            end else if (acc_addr == `SLBC_A_RX_SEL) begin
                rx_port_page_select <= acc_wdata;
            end else if (in_csi) begin
                if (csi_port_page_select[`SLBC_CSI_WEN]) begin
                    csi_regs[csi_idx] <= acc_wdata;
                end
            end else if (acc_addr == `SLBC_A_DBG) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (rx_port_page_select[i]) begin
                        dbg_scratch[i] <= acc_wdata & `SLBC_DBG_RW_MASK;
                    end
                end
            end
        end
    end

    // Register reads; unmapped and unimplemented bytes read zero
    always @* begin
        rd_mux = `SLBC_ZERO_BYTE;
        if (acc_addr == `SLBC_A_CTRL) begin
            rd_mux = link_test_control;
        end else if (acc_addr == `SLBC_A_CSI_SEL) begin
            rd_mux = csi_port_page_select;
        end else if (acc_addr == `SLBC_A_RX_SEL) begin
            rd_mux = rx_port_page_select;
        end else if (in_csi) begin
            if (!csi_port_page_select[`SLBC_CSI_RSEL]) begin
                rd_mux = csi_regs[csi_idx];
            end
        end else if (acc_addr == `SLBC_A_TALLY) begin
            rd_mux = tally_all[{rx_rsel, 3'b000} +: 8];
        end else if (acc_addr == `SLBC_A_DBG) begin
            rd_mux = dbg_scratch[rx_rsel];
            rd_mux[`SLBC_DBG_ACT] = remote_test_active_in[rx_rsel];
        end
    end

    always @(posedge clock_in) begin
        if (!nrst_in) begin
            loc_rdata_out  <= `SLBC_ZERO_BYTE;
            loc_rvalid_out <= 1'b0;
            cc_rdata_out   <= `SLBC_ZERO_BYTE;
            cc_rvalid_out  <= 1'b0;
        end else if (ce_in) begin
            loc_rvalid_out <= loc_rd_in;
            cc_rvalid_out  <= cc_rd_in & ~loc_busy;
            if (loc_rd_in) begin
                loc_rdata_out <= rd_mux;
            end else if (cc_rd_in && !loc_busy) begin
                cc_rdata_out <= rd_mux;
            end
        end
    end
endmodule

// File: verification/slbc_link_test_sva.sv
// Checker for the link self-test top: sequencer, back channel, gating, ports.
// Assumes binding to slbc_link_test; sees only its ports.
`timescale 1ns/1ps
module slbc_link_test_sva (
    input wire       clock_in,
    input wire       nrst_in,
    input wire       ce_in,
    input wire [7:0] loc_addr_in,
    input wire [7:0] loc_wdata_in,
    input wire       loc_wr_in,
    input wire       loc_rd_in,
    input wire       loc_rvalid_out,
    input wire [7:0] cc_addr_in,
    input wire [7:0] cc_wdata_in,
    input wire       cc_wr_in,
    input wire       cc_rd_in,
    input wire       cc_ready_out,
    input wire       cc_rvalid_out,
    input wire       bc_req_out,
    input wire [3:0] bc_port_mask_out,
    input wire [7:0] bc_addr_out,
    input wire [7:0] bc_data_out,
    input wire       bc_ack_in,
    input wire [3:0] pass_out,
    input wire       pattgen_en_in,
    input wire       test_active_out,
    input wire       output_enable_out,
    input wire       csi_lp11_hold_out
);
    reg  [1:0] gate;
    wire       ctl_wr = ce_in && ((loc_wr_in && loc_addr_in == 8'hb3) ||
                        (cc_wr_in && cc_ready_out && cc_addr_in == 8'hb3));
    wire [7:0] ctl_wd = loc_wr_in ? loc_wdata_in : cc_wdata_in;
    // Shadow of the gating field, since the register is not a port
    always @(posedge clock_in) begin
        if (!nrst_in)
            gate <= 2'b00;
        else if (ctl_wr)
            gate <= ctl_wd[7:6];
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence start_cmd_s; ctl_wr && ctl_wd[0] && !test_active_out; endsequence
    sequence stop_cmd_s; ctl_wr && !ctl_wd[0] && test_active_out && !bc_req_out; endsequence
    sequence stop_ack_s; bc_ack_in && bc_req_out && !bc_data_out[0]; endsequence
    start_issue_a: assert property (start_cmd_s |-> ##[1:2] (bc_req_out && bc_data_out[0]))
        else $error("start did not issue remote write");
    stop_issue_a: assert property (stop_cmd_s |-> ##[1:2] (bc_req_out && !bc_data_out[0]))
        else $error("stop did not issue remote write");
    stop_done_a: assert property (stop_ack_s |=> !test_active_out && !bc_req_out)
        else $error("test not left after stop ack");
    bc_target_a: assert property (bc_req_out |->
        bc_addr_out == 8'h14 && bc_port_mask_out == 4'hf && bc_data_out[7:3] == 5'h00)
        else $error("remote write target wrong");
    bc_hold_a: assert property (bc_req_out && !bc_ack_in |=> bc_req_out && $stable(bc_data_out))
        else $error("remote write dropped before ack");
    clk_sample_a: assert property (test_active_out && $past(test_active_out) |->
        $stable(bc_data_out[2:1]))
        else $error("clock select changed mid-test");
    out_gating_a: assert property (output_enable_out == (!test_active_out || gate == 2'b10))
        else $error("output gating wrong");
    lp11_idle_a: assert property (csi_lp11_hold_out == (test_active_out && !pattgen_en_in))
        else $error("idle state hold wrong");
    pass_idle_a: assert property (!test_active_out && !$past(test_active_out) |->
        pass_out == 4'hf)
        else $error("pass low outside test");
    loc_answer_a: assert property (ce_in && loc_rd_in |=> loc_rvalid_out)
        else $error("local read not answered");
    cc_answer_a: assert property (ce_in && cc_rd_in && cc_ready_out |=> cc_rvalid_out)
        else $error("channel read not answered");
    cc_refuse_a: assert property (cc_ready_out == !(loc_wr_in || loc_rd_in))
        else $error("channel ready wrong");
endmodule
bind slbc_link_test slbc_link_test_sva slbc_link_test_sva_inst (.*);

// File: verification/slbc_remote_model.sv
// Remote serializer model: takes back-channel writes, sends the test pattern.
// Assumes one outstanding write from the hub, on the same clock.
`timescale 1ns/1ps
module slbc_remote_model (
    input  wire       clock_in,
    input  wire       nrst_in,
    input  wire       slow_in,
    input  wire [3:0] err_in,
    input  wire       bc_req_in,
    input  wire [7:0] bc_data_in,
    output reg        bc_ack_out,
    output reg  [7:0] reg14_out,
    output wire [3:0] active_out,
    output reg  [3:0] bit_out,
    output wire [3:0] valid_out
);
    reg  [2:0] wait_cnt;
    reg  [6:0] prbs;
    wire       nb = prbs[6] ^ prbs[5];
    assign active_out = {4{reg14_out[0]}};
    assign valid_out  = active_out;
    always @(posedge clock_in) begin
        bc_ack_out <= 1'b0;
        if (!nrst_in) begin
            wait_cnt  <= 3'h0;
            reg14_out <= 8'h00;
            prbs      <= 7'h7f;
        // frames arrive clean, so every write is accepted
        end else if (bc_req_in && !bc_ack_out) begin
            if (wait_cnt >= (slow_in ? 3'h5 : 3'h0)) begin
                bc_ack_out <= 1'b1;
                reg14_out  <= bc_data_in;
                wait_cnt   <= 3'h0;
            end else
                wait_cnt <= wait_cnt + 3'h1;
        end
        // full-rate pattern whichever clock source is chosen
        if (reg14_out[0]) begin
            prbs    <= {prbs[5:0], nb};
            bit_out <= {4{nb}} ^ err_in;
        end else
            bit_out <= ~bit_out;
    end
endmodule

// File: verification/tb.sv
// Self-checking bench for slbc_link_test with the remote serializer model.
// Assumes the hand-over timing: reads answer one cycle after the strobe.
`timescale 1ns/1ps
module tb;
    reg         clock_in, nrst_in, ce_in, loc_wr_in, loc_rd_in, cc_wr_in, cc_rd_in;
    reg  [7:0]  loc_addr_in, loc_wdata_in, cc_addr_in, cc_wdata_in, q;
    reg  [3:0]  rx_lock_in, err;
    reg         pattgen_en_in, slow;
    reg  [7:0]  scr [0:3];
    integer     seed, err_count, total_checks, lows, p, r;
    wire [7:0]  loc_rdata_out, cc_rdata_out, bc_addr_out, bc_data_out, reg14;
    wire [3:0]  bc_port_mask_out, rx_bit_in, rx_bit_valid_in, act, pass_out;
    wire        loc_rvalid_out, cc_ready_out, cc_rvalid_out, bc_req_out, bc_ack_in;
    wire        test_active_out, output_enable_out, csi_lp11_hold_out, csi_tx_enable_out;
    slbc_link_test slbc_link_test_inst (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .loc_addr_in(loc_addr_in), .loc_wdata_in(loc_wdata_in), .loc_wr_in(loc_wr_in),
        .loc_rd_in(loc_rd_in), .loc_rdata_out(loc_rdata_out), .loc_rvalid_out(loc_rvalid_out),
        .cc_addr_in(cc_addr_in), .cc_wdata_in(cc_wdata_in), .cc_wr_in(cc_wr_in),
        .cc_rd_in(cc_rd_in), .cc_ready_out(cc_ready_out), .cc_rdata_out(cc_rdata_out),
        .cc_rvalid_out(cc_rvalid_out), .bc_req_out(bc_req_out), .bc_port_mask_out(bc_port_mask_out),
        .bc_addr_out(bc_addr_out), .bc_data_out(bc_data_out), .bc_ack_in(bc_ack_in),
        .rx_lock_in(rx_lock_in), .rx_bit_in(rx_bit_in), .rx_bit_valid_in(rx_bit_valid_in),
        .remote_test_active_in(act), .pass_out(pass_out), .pattgen_en_in(pattgen_en_in),
        .test_active_out(test_active_out), .output_enable_out(output_enable_out),
        .csi_lp11_hold_out(csi_lp11_hold_out), .csi_tx_enable_out(csi_tx_enable_out));
    slbc_remote_model slbc_remote_model_inst (.clock_in(clock_in), .nrst_in(nrst_in),
        .slow_in(slow), .err_in(err), .bc_req_in(bc_req_out), .bc_data_in(bc_data_out),
        .bc_ack_out(bc_ack_in), .reg14_out(reg14), .active_out(act), .bit_out(rx_bit_in),
        .valid_out(rx_bit_valid_in));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    always @(negedge clock_in) if (pass_out[1] === 1'b0) lows = lows + 1;
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock_in);
            #1;
        end
    endtask
    task fail_wait;
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: wait ran out", $time);
            close_out;
        end
    endtask
    // One access on either port; called just after a rising edge
    task acc(input cc, input rd, input [7:0] a, input [7:0] d, output [7:0] v);
        integer i;
        begin
            {cc_addr_in, cc_wdata_in, cc_wr_in, cc_rd_in} = {a, d, !rd && cc, rd && cc};
            {loc_addr_in, loc_wdata_in, loc_wr_in, loc_rd_in} = {a, d, !rd && !cc, rd && !cc};
            tick(1);
            {cc_wr_in, cc_rd_in, loc_wr_in, loc_rd_in} = 4'h0;
            v = 8'h00;
            for (i = 0; rd && i < 4; i = i + 1) begin
                if ((cc ? cc_rvalid_out : loc_rvalid_out) === 1'b1) begin
                    v = cc ? cc_rdata_out : loc_rdata_out;
                    break;
                end
                tick(1);
            end
            if (rd && i == 4)
                fail_wait;
            tick(1);
        end
    endtask
    task rdc(input cc, input [7:0] a, input [7:0] exp);
        begin
            acc(cc, 1'b1, a, 8'h00, q);
            chk(q, exp);
        end
    endtask
    // Waits for the run state (want 1) or for idle (want 0)
    task wait_st(input integer want);
        integer i;
        begin
            for (i = 0; i < 40 && (want ? !(test_active_out === 1'b1 && bc_req_out === 1'b0)
                 : test_active_out !== 1'b0); i = i + 1)
                tick(1);
            if (i == 40)
                fail_wait;
        end
    endtask
    function [7:0] exp_tally(input integer m, input integer pt);
        exp_tally = (m != 2) ? 8'h00 : (pt == 0) ? 8'hfe : (pt == 1) ? 8'h00 : 8'hff;
    endfunction
    task run_test(input integer m);
        reg [1:0] ck;
        reg [1:0] gt;
        begin
            ck = $random(seed);
            gt = m[0] ? 2'b00 : 2'b10;
            slow = m[0];
            lows = 0;
            if (m == 2)
                rx_lock_in = 4'b0111;
            acc(m[0], 1'b0, 8'hb3, {gt, 3'b000, ck, 1'b1}, q);
            wait_st(1);
            chk(reg14, {5'h00, ck, 1'b1}); // clock select copied
            chk(output_enable_out, gt == 2'b10); // gating code
            pattgen_en_in = $random(seed);
            tick(1);
            chk(csi_lp11_hold_out, !pattgen_en_in); // idle hold
            acc(0, 1'b0, 8'h4c, 8'h00, q);
            rdc(0, 8'hd0, {scr[0][7:6], 1'b1, scr[0][4:0]}); // remote active seen
            acc(0, 1'b0, 8'hb3, {gt, 3'b000, ~ck, 1'b1}, q);
            rdc(1, 8'hb3, {gt, 3'b000, ~ck, 1'b1}); // control reads back
            if (m == 1)
                repeat (3) begin
                    err = 4'h2;
                    tick(1);
                    err = 4'h0;
                    tick(11);
                end
            if (m == 2) begin
                err = 4'h1;
                tick(20);
                rx_lock_in[2] = 1'b0;
                tick(280);
                err = 4'h0;
            end
            tick(6);
            for (p = 0; p < 4; p = p + 1) begin
                acc(0, 1'b0, 8'h4c, p << 4, q);
                acc(p[0], 1'b1, 8'h57, 8'h00, q);
                if (m == 1 && p == 1)
                    chk(q >= 8'h01 && q <= 8'h09, 8'h01); // errors counted
                else
                    chk(q, exp_tally(m, p)); // saturation and lock loss
            end
            chk((m == 1) ? (lows >= 1 && lows <= 9) : (lows == 0), 8'h01); // pass pulses
            acc(0, 1'b0, 8'hb3, 8'h00, q);
            wait_st(0);
            chk(reg14, {5'h00, ck, 1'b0}); // first clock select kept
            chk(output_enable_out, 8'h01); // normal operation back
            rx_lock_in = 4'hf;
            $display("test %0d done", m);
        end
    endtask
    initial begin
        seed = 40619;
        {err_count, total_checks, lows} = 0;
        {nrst_in, loc_wr_in, loc_rd_in, cc_wr_in, cc_rd_in, pattgen_en_in, slow} = 0;
        {loc_addr_in, loc_wdata_in, cc_addr_in, cc_wdata_in, err} = 0;
        ce_in = 1'b1;
        rx_lock_in = 4'hf;
        tick(2);
        nrst_in = 1'b1;
        chk(pass_out, 8'h0f); // pass high after reset
        rdc(0, 8'hb3, 8'h00); // control clear after reset
        rdc(1, 8'h50, 8'h00); // unused paged address
        acc(0, 1'b0, 8'h57, 8'hff, q);
        rdc(0, 8'h57, 8'h00); // tally is read-only
        scr[0] = $random(seed);
        acc(0, 1'b0, 8'h4c, 8'h0f, q);
        acc(1, 1'b0, 8'hd0, scr[0], q);
        for (p = 1; p < 4; p = p + 1) scr[p] = scr[0];
        for (p = 0; p < 3; p = p + 1) begin
            scr[p] = $random(seed);
            acc(0, 1'b0, 8'h4c, 8'h01 << p, q);
            acc(p[0], 1'b0, 8'hd0, scr[p], q);
        end
        for (p = 0; p < 4; p = p + 1) begin
            acc(0, 1'b0, 8'h4c, p << 4, q);
            rdc(p[1], 8'hd0, scr[p] & 8'hdf); // paged debug register
        end
        q = $random(seed);
        scr[3] = q;
        acc(0, 1'b0, 8'h32, 8'h01, q);
        acc(0, 1'b0, 8'h33, scr[3], q);
        acc(1, 1'b0, 8'h32, 8'h00, q);
        acc(0, 1'b0, 8'h33, ~scr[3], q);
        rdc(0, 8'h33, scr[3]); // paged write enable
        chk(csi_tx_enable_out, scr[3][0]); // port 0 control bit
        scr[0] = scr[0] & 8'hdf;
        for (r = 0; r < 4; r = r + 1) run_test(r);
        close_out;
    end
endmodule
